// *** shared/smi_map.svh ***
// Constants of the microstep indexer: timing, register offsets and fields.
// Assumes a 100 MHz core clock; included by bare name wherever needed.
`ifndef SMI_MAP_SVH
`define SMI_MAP_SVH
// ****************************************************************
// Timing
// ****************************************************************
`define SMI_CLK_PERIOD_NS  10
`define SMI_PWM_FREQ_KHZ   50
`define SMI_PWM_CYCLES     (1000000 / (`SMI_PWM_FREQ_KHZ * `SMI_CLK_PERIOD_NS))
`define SMI_BLANK_NS       3750
`define SMI_BLANK_CYCLES   ((`SMI_BLANK_NS + `SMI_CLK_PERIOD_NS - 1) \
                            / `SMI_CLK_PERIOD_NS)
`define SMI_SENSE_GAIN     5
`define SMI_PCT_FULL       100
`define SMI_HOME_IDX       7'h10
`define SMI_QUARTER_TURN   7'h20
`define SMI_FULL_OFFSET    7'h10
// ****************************************************************
// Registers
// ****************************************************************
`define SMI_REG_CTRL       6'h00
`define SMI_REG_STATUS     6'h01
`define SMI_REG_REF_A      6'h02
`define SMI_REG_REF_B      6'h03
`define SMI_REG_LEVEL      6'h04
`define SMI_REG_CHOP       6'h05
`define SMI_REG_STEPS      6'h06
`define SMI_CTRL_HOME_BIT  2
`define SMI_CTRL_RESET     2'h3
`define SMI_REF_RESET      10'h3ff
`define SMI_STAT_MODE_POS  8
`define SMI_STAT_PIN_POS   12
`define SMI_STAT_DRIVE_POS 16
`endif

// *** shared/smi_pkg.sv ***
// Types shared by the microstep indexer modules.
// Assumes nothing beyond a SystemVerilog package compile.
`default_nettype none
package smi_pkg;
    typedef logic [6:0] smi_idx_t;
    typedef logic [6:0] smi_pct_t;
    typedef enum logic [2:0] {
        SMI_MODE_FULL, SMI_MODE_HALF, SMI_MODE_QUARTER,
        SMI_MODE_EIGHTH, SMI_MODE_SIXTEENTH, SMI_MODE_32ND
    } smi_mode_t;
    typedef enum logic [1:0] {
        SMI_CH_OFF, SMI_CH_BLANK, SMI_CH_ON
    } smi_chop_state_t;
endpackage : smi_pkg
`default_nettype wire

// *** shared/smi_bridge_if.sv ***
// Signals between the indexer core and one bridge chopper.
// Assumes both ends run on the same core clock.
`default_nettype none
interface smi_bridge_if;
    logic       pwm_start;
    logic       enable;
    logic [6:0] pct;
    logic       neg;
    logic [9:0] full_scale;
    logic [9:0] sense;
    logic       out_pos;
    logic       out_neg;
    logic       chopped;
    logic       drive;
    modport ctl (output pwm_start, enable, pct, neg, full_scale, sense,
                 input  out_pos, out_neg, chopped, drive);
    modport drv (input  pwm_start, enable, pct, neg, full_scale, sense,
                 output out_pos, out_neg, chopped, drive);
endinterface : smi_bridge_if
`default_nettype wire

// *** verilog/smi_sine_lut.sv ***
// Winding current magnitude and sign for one electrical phase index.
// Assumes a 128-state electrical turn, index 0 at 0 degrees.
`default_nettype none
module smi_sine_lut
    import smi_pkg::*;
(
    input  wire smi_idx_t idx_i, // Phase index, 0 to 127.
    output smi_pct_t      pct_o, // Current magnitude in percent.
    output logic          neg_o  // High for negative current.
);
    // Quarter wave of the table; the other quadrants mirror it.
    localparam smi_pct_t QW [0:32] = '{
        7'h00, 7'h05, 7'h0a, 7'h0f, 7'h14, 7'h18, 7'h1d, 7'h22, 7'h26,
        7'h2b, 7'h2f, 7'h33, 7'h38, 7'h3c, 7'h3f, 7'h43, 7'h47, 7'h4a,
        7'h4d, 7'h50, 7'h53, 7'h56, 7'h58, 7'h5a, 7'h5c, 7'h5e, 7'h60,
        7'h61, 7'h62, 7'h63, 7'h64, 7'h64, 7'h64};
    wire logic [5:0] k      = {1'b0, idx_i[4:0]};
    wire logic [5:0] k_back = 6'h20 - k;
    // Odd quadrants read the quarter wave backwards.
    assign pct_o = idx_i[5] ? QW[k_back] : QW[k];
    assign neg_o = idx_i[6] && (pct_o != 7'h00);
endmodule : smi_sine_lut
`default_nettype wire

// *** verilog/smi_chopper.sv ***
// Fixed-period current chopper for one H-bridge winding.
// Assumes pwm_start is a one-cycle pulse once per PWM period.
`include "smi_map.svh"
`default_nettype none
module smi_chopper
    import smi_pkg::*;
#(
    parameter int BLANK_CYCLES = `SMI_BLANK_CYCLES
) (
    input  wire logic clk_i, // Core clock.
    input  wire logic rst_i, // Synchronous reset, high.
    smi_bridge_if.drv br     // Link to the indexer core.
);
    localparam logic [19:0] GAIN_X100 = 20'(`SMI_SENSE_GAIN * `SMI_PCT_FULL);
    localparam logic [8:0]  BLANK_LAST = 9'(BLANK_CYCLES - 1);
    smi_chop_state_t state, next_state;
    logic [8:0]      cnt, next_cnt;
    // Compare 5 x sense against the DAC-scaled reference, both x100.
    wire logic [19:0] sense_x = 20'(br.sense) * GAIN_X100;
    wire logic [19:0] ref_x   = 20'(br.full_scale) * 20'(br.pct);
    wire logic        trip    = sense_x >= ref_x;
    wire logic        run     = br.enable && (br.pct != 7'h00);
    // Period start wins; the off latch holds until then.
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        if (br.pwm_start) begin
            next_state = run ? SMI_CH_BLANK : SMI_CH_OFF;
            next_cnt   = BLANK_LAST;
        end else begin
            case (state)
                SMI_CH_BLANK: begin
                    if (cnt == 9'h000) next_state = SMI_CH_ON;
                    else next_cnt = cnt - 9'h001;
                end
                SMI_CH_ON: if (trip) next_state = SMI_CH_OFF;
                default: next_state = state;
            endcase
        end
    end
    // Bridge outputs are registered so they never glitch.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state      <= SMI_CH_OFF;
            cnt        <= 9'h000;
            br.out_pos <= 1'b0;
            br.out_neg <= 1'b0;
            br.chopped <= 1'b0;
            br.drive   <= 1'b0;
        end else begin
            state      <= next_state;
            cnt        <= next_cnt;
            br.drive   <= next_state != SMI_CH_OFF;
            br.out_pos <= (next_state != SMI_CH_OFF) && !br.neg;
            br.out_neg <= (next_state != SMI_CH_OFF) && br.neg;
            br.chopped <= (state == SMI_CH_ON) && trip && !br.pwm_start;
        end
    end
endmodule : smi_chopper
`default_nettype wire

// *** verilog/smi_indexer_top.sv ***
// Microstep indexer with two chopped H-bridge drives and a Wishbone slave.
// Assumes step, direction and mode pins are synchronous to clk_i and the
// sense inputs are digitised winding sense samples on the same clock.
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`include "smi_map.svh"
`default_nettype none
module smi_indexer_top
    import smi_pkg::*;
#(
    parameter int PWM_CYCLES   = `SMI_PWM_CYCLES,
    parameter int BLANK_CYCLES = `SMI_BLANK_CYCLES
) (
    input  wire logic        clk_i,                    // Core clock.
    input  wire logic        rst_i,                    // Sync reset, high.
    input  wire logic        wb_cyc_i,                 // Bus cycle.
    input  wire logic        wb_stb_i,                 // Bus strobe.
    input  wire logic        wb_we_i,                  // Write enable.
    input  wire logic [7:0]  wb_adr_i,                 // Byte address.
    input  wire logic [3:0]  wb_sel_i,                 // Byte lanes.
    input  wire logic [31:0] wb_dat_i,                 // Write data.
    output logic      [31:0] wb_dat_o,                 // Read data.
    output logic             wb_ack_o,                 // Acknowledge.
    input  wire logic        step_i,                   // Step pulse.
    input  wire logic        dir_i,                    // Direction level.
    input  wire logic        resolution_select_bit0_i, // Mode bit 0.
    input  wire logic        resolution_select_bit1_i, // Mode bit 1.
    input  wire logic        resolution_select_bit2_i, // Mode bit 2.
    input  wire logic        indexer_home_reset_n_i,   // Home, low.
    input  wire logic [9:0]  winding_sense_input_a_i,  // Sense A sample.
    input  wire logic [9:0]  winding_sense_input_b_i,  // Sense B sample.
    output logic             winding_out_pos_a_o,      // Bridge A out 1.
    output logic             winding_out_neg_a_o,      // Bridge A out 2.
    output logic             winding_out_pos_b_o,      // Bridge B out 1.
    output logic             winding_out_neg_b_o       // Bridge B out 2.
);
    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam logic [10:0] PWM_LAST = 11'(PWM_CYCLES - 1);

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  bridge_en;
    logic [9:0]  ref_level [2];
    logic [1:0]  chop_flag;
    logic [15:0] step_count;
    logic [6:0]  idx;

    // Request decode; a request is taken in its first cycle.
    wire logic        req      = wb_cyc_i && wb_stb_i && !ack;
    wire logic        wr       = req && wb_we_i;
    wire logic [5:0]  word     = wb_adr_i[7:2];
    wire logic        hit_ctrl = word == `SMI_REG_CTRL;
    wire logic        hit_stat = word == `SMI_REG_STATUS;
    wire logic        hit_refa = word == `SMI_REG_REF_A;
    wire logic        hit_refb = word == `SMI_REG_REF_B;
    wire logic        hit_lvl  = word == `SMI_REG_LEVEL;
    wire logic        hit_chop = word == `SMI_REG_CHOP;
    wire logic        hit_step = word == `SMI_REG_STEPS;

    // Byte-lane mask so partial writes leave other lanes alone.
    wire logic [31:0] lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                              {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire logic [31:0] wmask = wb_dat_i & lane;

    wire logic        wr_ctrl  = wr && hit_ctrl;
    wire logic        wr_refa  = wr && hit_refa;
    wire logic        wr_refb  = wr && hit_refb;
    wire logic        wr_chop  = wr && hit_chop;
    wire logic        sw_home  = wr_ctrl && wmask[`SMI_CTRL_HOME_BIT];

    wire logic [31:0] ctrl_new = ({30'h0, bridge_en} & ~lane) | wmask;
    wire logic [31:0] refa_new = ({22'h0, ref_level[0]} & ~lane) | wmask;
    wire logic [31:0] refb_new = ({22'h0, ref_level[1]} & ~lane) | wmask;

    // Ack one cycle after the request; it drops the cycle after that.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack      <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack      <= req;
            wb_dat_o <= req ? rdata : 32'h0000_0000;
        end
    end
    assign wb_ack_o = ack;

    // Software-written control: bridge enables and full-scale references.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bridge_en    <= `SMI_CTRL_RESET;
            ref_level[0] <= `SMI_REF_RESET;
            ref_level[1] <= `SMI_REF_RESET;
        end else begin
            if (wr_ctrl) bridge_en    <= ctrl_new[1:0];
            if (wr_refa) ref_level[0] <= refa_new[9:0];
            if (wr_refb) ref_level[1] <= refb_new[9:0];
        end
    end

    // ****************************************************************
    // Resolution decode
    // ****************************************************************
    wire logic [2:0] res_code = {resolution_select_bit2_i,
                                 resolution_select_bit1_i,
                                 resolution_select_bit0_i};
    smi_mode_t mode;

    // Codes five to seven all select the finest step.
    assign mode = (res_code == 3'h0) ? SMI_MODE_FULL      :
                  (res_code == 3'h1) ? SMI_MODE_HALF      :
                  (res_code == 3'h2) ? SMI_MODE_QUARTER   :
                  (res_code == 3'h3) ? SMI_MODE_EIGHTH    :
                  (res_code == 3'h4) ? SMI_MODE_SIXTEENTH :
                                       SMI_MODE_32ND;

    // Grid size in fine states; full step sits on the 45-degree grid.
    wire logic [6:0] grid = (mode == SMI_MODE_FULL)      ? 7'h20 :
                            (mode == SMI_MODE_HALF)      ? 7'h10 :
                            (mode == SMI_MODE_QUARTER)   ? 7'h08 :
                            (mode == SMI_MODE_EIGHTH)    ? 7'h04 :
                            (mode == SMI_MODE_SIXTEENTH) ? 7'h02 :
                                                           7'h01;
    wire logic [6:0] grid_off = (mode == SMI_MODE_FULL) ?
                                `SMI_FULL_OFFSET : 7'h00;

    // ****************************************************************
    // Indexer
    // ****************************************************************
    logic step_q;

    // A pin that is left low never yields an edge, so an idle,
    // undriven step input cannot move the motor.
    wire logic step_rise = step_i && !step_q;
    wire logic home_pin  = !indexer_home_reset_n_i;
    wire logic home_req  = home_pin || sw_home;

    // Position relative to the grid of the selected resolution.
    wire logic [6:0] rel     = idx - grid_off;
    wire logic [6:0] gmask   = grid - 7'h01;
    wire logic [6:0] floor_g = rel & ~gmask;
    wire logic       on_grid = (rel & gmask) == 7'h00;

    // Off-grid positions snap to the nearest valid state ahead.
    wire logic [6:0] idx_up = floor_g + grid + grid_off;
    wire logic [6:0] idx_dn = on_grid ? floor_g - grid + grid_off
                                      : floor_g + grid_off;
    wire logic [6:0] next_idx = dir_i ? idx_up : idx_dn;

    // Step edge detector starts low, matching an idle pin.
    always_ff @(posedge clk_i) begin
        if (rst_i) step_q <= 1'b0;
        else       step_q <= step_i;
    end

    // Home wins over a step that arrives in the same cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i || home_req) begin
            idx <= `SMI_HOME_IDX;
        end else if (step_rise) begin
            idx <= next_idx;
        end
    end

    // Count of accepted steps, for software to track motion.
    always_ff @(posedge clk_i) begin
        if (rst_i || home_req) begin
            step_count <= 16'h0000;
        end else if (step_rise) begin
            step_count <= step_count + 16'h0001;
        end
    end

    // ****************************************************************
    // PWM timebase
    // ****************************************************************
    logic [10:0] pwm_cnt;

    // Free-running period counter; the wrap starts every bridge.
    always_ff @(posedge clk_i) begin
        if (rst_i)                    pwm_cnt <= 11'h000;
        else if (pwm_cnt == PWM_LAST) pwm_cnt <= 11'h000;
        else                          pwm_cnt <= pwm_cnt + 11'h001;
    end
    wire logic pwm_start = pwm_cnt == 11'h000;

    // ****************************************************************
    // Bridges
    // ****************************************************************
    smi_bridge_if br [2] ();
    logic [9:0] sense_in [2];
    logic [1:0] out_pos;
    logic [1:0] out_neg;
    logic [1:0] chopped;
    logic [1:0] drive;
    logic [6:0] level_pct [2];
    logic [1:0] level_neg;

    assign sense_in[0] = winding_sense_input_a_i;
    assign sense_in[1] = winding_sense_input_b_i;

    // Winding A follows the cosine, a quarter turn ahead of B.
    for (genvar i = 0; i < 2; i++) begin : g_bridge
        wire logic [6:0] phase = (i == 0) ? idx + `SMI_QUARTER_TURN : idx;

        smi_sine_lut u_lut (
            .idx_i (phase),
            .pct_o (br[i].pct),
            .neg_o (br[i].neg)
        );

        // Each winding has its own chopper and blanking counter.
        assign br[i].pwm_start  = pwm_start;
        assign br[i].enable     = bridge_en[i];
        assign br[i].full_scale = ref_level[i];
        assign br[i].sense      = sense_in[i];

        smi_chopper #(
            .BLANK_CYCLES (BLANK_CYCLES)
        ) u_chop (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .br    (br[i])
        );

        assign out_pos[i]   = br[i].out_pos;
        assign out_neg[i]   = br[i].out_neg;
        assign chopped[i]   = br[i].chopped;
        assign drive[i]     = br[i].drive;
        assign level_pct[i] = br[i].pct;
        assign level_neg[i] = br[i].neg;
    end

    assign winding_out_pos_a_o = out_pos[0];
    assign winding_out_neg_a_o = out_neg[0];
    assign winding_out_pos_b_o = out_pos[1];
    assign winding_out_neg_b_o = out_neg[1];

    // Sticky chop flags; a new chop in the clearing cycle survives.
    wire logic [1:0] chop_clr = wr_chop ? wmask[1:0] : 2'h0;
    always_ff @(posedge clk_i) begin
        if (rst_i) chop_flag <= 2'h0;
        else       chop_flag <= (chop_flag & ~chop_clr) | chopped;
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    wire logic [31:0] stat_word =
        {14'h0, drive, 3'h0, home_pin, 1'b0, 3'(mode), 1'b0, idx};
    wire logic [31:0] lvl_word =
        {16'h0, level_neg[1], level_pct[1], level_neg[0], level_pct[0]};

    // Unmapped words read as zero and still get an ack.
    assign rdata = hit_ctrl ? {30'h0, bridge_en}    :
                   hit_stat ? stat_word             :
                   hit_refa ? {22'h0, ref_level[0]} :
                   hit_refb ? {22'h0, ref_level[1]} :
                   hit_lvl  ? lvl_word              :
                   hit_chop ? {30'h0, chop_flag}    :
                   hit_step ? {16'h0, step_count}   :
                              32'h0000_0000;

    // The controller must keep dir and select steady around the step
    // edge; they are sampled in the same cycle that sees the edge.
endmodule : smi_indexer_top
`default_nettype wire

// *** bench/smi_step_ctrl_model.sv ***
// Model of the motion controller that issues step, direction and mode.
// Assumes one core clock; a go pulse asks for one step.
`default_nettype none
module smi_step_ctrl_model (
    input  wire logic       clk_i,      // Core clock.
    input  wire logic       go_i,       // Request one step.
    input  wire logic       dir_req_i,  // Wanted direction.
    input  wire logic [2:0] mode_req_i, // Wanted mode code.
    input  wire logic       slow_i,     // Long pulse timing.
    output logic            step_o,     // Step pin.
    output logic            dir_o,      // Direction pin.
    output logic [2:0]      mode_o,     // Mode pins.
    output logic            done_o      // Step finished.
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt = 0;
    logic busy = 1'b0;
    initial {step_o, dir_o, mode_o, done_o} = '0;
    // Levels are set first and held while busy, so they never move at a rise.
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (go_i && !busy) begin
            busy   <= 1'b1;
            cnt    <= 0;
            dir_o  <= dir_req_i;
            mode_o <= mode_req_i;
        end else if (busy) begin
            cnt <= cnt + 1;
            if (cnt == 1) step_o <= 1'b1;
            if (cnt == (slow_i ? 8 : 2)) step_o <= 1'b0;
            if (cnt == (slow_i ? 14 : 4)) begin
                busy   <= 1'b0;
                done_o <= 1'b1;
            end
        end
    end
endmodule : smi_step_ctrl_model
`default_nettype wire

// *** bench/smi_indexer_properties.sv ***
// Checker for bus timing and bridge drive behaviour of the indexer top.
// Assumes it is bound into smi_indexer_top and sees only its ports.
`default_nettype none
module smi_indexer_properties #(
    parameter int PWM_CYCLES   = 100,
    parameter int BLANK_CYCLES = 10
) (
    input wire logic        clk_i,               // Core clock.
    input wire logic        rst_i,               // Sync reset.
    input wire logic        wb_cyc_i,            // Bus cycle.
    input wire logic        wb_stb_i,            // Bus strobe.
    input wire logic [31:0] wb_dat_o,            // Read data.
    input wire logic        wb_ack_o,            // Acknowledge.
    input wire logic [9:0]  winding_sense_input_a_i, // Sense A.
    input wire logic        winding_out_pos_a_o, // Bridge A out 1.
    input wire logic        winding_out_neg_a_o, // Bridge A out 2.
    input wire logic        winding_out_pos_b_o, // Bridge B out 1.
    input wire logic        winding_out_neg_b_o  // Bridge B out 2.
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire drive_a = winding_out_pos_a_o | winding_out_neg_a_o;
    logic        drive_q;
    logic        seen_a;
    logic [31:0] on_a;
    logic [31:0] gap_a;
    wire rise_a = drive_a & ~drive_q;
    // Counters of on time and of the spacing between turn-ons.
    always_ff @(posedge clk_i) begin
        drive_q <= rst_i ? 1'b0 : drive_a;
        on_a    <= (rst_i || !drive_a) ? '0 : on_a + 32'h1;
        gap_a   <= (rst_i || rise_a) ? 32'h1 : gap_a + 32'h1;
        seen_a  <= rst_i ? 1'b0 : (seen_a | rise_a);
    end
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("request not answered next cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero when idle");
    a_polar_a: assert property (
        !(winding_out_pos_a_o && winding_out_neg_a_o))
        else $error("bridge A drives both ways");
    a_polar_b: assert property (
        !(winding_out_pos_b_o && winding_out_neg_b_o))
        else $error("bridge B drives both ways");
    a_blank_hold: assert property ($rose(drive_a) |=> drive_a [*8])
        else $error("on phase shorter than blanking");
    a_trip_off: assert property (drive_a && on_a > BLANK_CYCLES + 6
        |-> $past(winding_sense_input_a_i, 3) != 10'h3ff)
        else $error("bridge A not chopped on high sense");
    a_period_start: assert property (rise_a && seen_a
        |-> gap_a % PWM_CYCLES == 0)
        else $error("turn on away from period start");
    c_chop: cover property ($fell(drive_a));
    c_read: cover property (wb_ack_o && wb_dat_o != 32'h0);
    c_neg: cover property (winding_out_neg_a_o);
endmodule : smi_indexer_properties
bind smi_indexer_top smi_indexer_properties #(
    .PWM_CYCLES(PWM_CYCLES), .BLANK_CYCLES(BLANK_CYCLES)) i_props (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .winding_sense_input_a_i(winding_sense_input_a_i),
    .winding_out_pos_a_o(winding_out_pos_a_o),
    .winding_out_neg_a_o(winding_out_neg_a_o),
    .winding_out_pos_b_o(winding_out_pos_b_o),
    .winding_out_neg_b_o(winding_out_neg_b_o));
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench: bus reads, stepping in all modes, chopping.
// Assumes the step controller model and the bound checker.
`include "smi_map.svh"
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
    $display("[FAIL] %0t value mismatch", $time); end end
module tb_top;
    import smi_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0, dr = 0;
    logic slw = 0, home_n = 1, rnd = 1, step, dir, done;
    logic [2:0] md = 0, mode;
    logic [7:0] adr = 0;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 0, rdat, q, seed = 32'hfbf55593;
    logic [9:0] sa = 0, sb = 0, fix = 0;
    logic pa, na, pb, nb, ack;
    smi_idx_t idx = `SMI_HOME_IDX;
    int err_total = 0, tests_run = 0;
    always #5 clk_i = ~clk_i;
    smi_indexer_top #(.PWM_CYCLES(100), .BLANK_CYCLES(10)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .step_i(step), .dir_i(dir),
        .resolution_select_bit0_i(mode[0]), .resolution_select_bit1_i(mode[1]),
        .resolution_select_bit2_i(mode[2]), .indexer_home_reset_n_i(home_n),
        .winding_sense_input_a_i(sa), .winding_sense_input_b_i(sb),
        .winding_out_pos_a_o(pa), .winding_out_neg_a_o(na),
        .winding_out_pos_b_o(pb), .winding_out_neg_b_o(nb));
    smi_step_ctrl_model i_ctrl (.clk_i(clk_i), .go_i(go), .dir_req_i(dr),
        .mode_req_i(md), .slow_i(slw), .step_o(step), .dir_o(dir),
        .mode_o(mode), .done_o(done));
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // Next grid point above or below, grids of 32, 16, 8, 4, 2 and 1.
    function automatic smi_idx_t nxt(smi_idx_t i, logic [2:0] m, logic d);
        int s, o, r;
        s = (m > 3'd4) ? 1 : 32 >> m;
        o = (m == 3'd0) ? 16 : 0;
        r = (i - o) & 127;
        r = d ? (r / s + 1) * s : ((r + s - 1) / s - 1) * s;
        return smi_idx_t'((r + o) & 127);
    endfunction : nxt
    function automatic smi_mode_t mode_of(logic [2:0] m);
        return (m > 3'd4) ? SMI_MODE_32ND : smi_mode_t'(m);
    endfunction : mode_of
    // Sense samples: random mix with full scale, or a fixed level.
    always @(posedge clk_i) begin
        seed <= lfsr(seed);
        sa <= rnd ? (seed[0] ? 10'h3ff : seed[12:3]) : fix;
        sb <= rnd ? (seed[1] ? 10'h3ff : seed[22:13]) : fix;
    end
    // Request held until ack is seen at a rising edge; data taken there.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s = 4'hf);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask : bus
    task automatic do_step(input logic d, input logic [2:0] m);
        @(posedge clk_i);
        {go, dr, md, slw} <= {1'b1, d, m, seed[7]};
        @(posedge clk_i);
        go <= 1'b0;
        do @(negedge clk_i); while (done !== 1'b1);
        bus(0, 8'h04, 0);
        if (home_n) idx = nxt(idx, m, d);
        `CHK(q[6:0], idx)
        `CHK(q[10:8], mode_of(m))
    endtask : do_step
    task automatic wrap_up;
        if (err_total == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic go_home;
        @(posedge clk_i);
        home_n <= 1'b0;
        idx = `SMI_HOME_IDX;
        do_step(1, 3'd1);
        `CHK(q[6:0], `SMI_HOME_IDX)
        `CHK(q[12], 1'b1)
        bus(0, 8'h18, 0);
        `CHK(q[15:0], 16'h0)
        home_n <= 1'b1;
    endtask : go_home
    initial begin
        #500000;
        err_total++;
        wrap_up();
    end
    // Reset values, lanes, stepping in every mode, then chop threshold.
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, 8'h04, 0);
        `CHK(q[10:0], {3'd0, 1'b0, 7'h10})
        bus(0, 8'h00, 0);
        `CHK(q, 32'h3)
        bus(0, 8'h10, 0);
        `CHK(q[15:0], 16'h4747)
        bus(0, 8'hfc, 0);
        `CHK(q, 32'h0)
        bus(1, 8'h0c, 0, 4'h1);
        bus(0, 8'h0c, 0);
        `CHK(q[9:0], 10'h300)
        bus(1, 8'h0c, 32'h3ff);
        for (int k = 0; k < 8; k++) do_step(k[1], k[2:0]);
        repeat (50) do_step(seed[3], seed[6:4]);
        go_home();
        rnd <= 1'b0;
        fix <= 10'd145;
        repeat (300) @(posedge clk_i);
        bus(1, 8'h14, 32'h3);
        repeat (200) @(posedge clk_i);
        bus(0, 8'h14, 0);
        `CHK(q[1:0], 2'b00)
        fix <= 10'd146;
        repeat (200) @(posedge clk_i);
        bus(0, 8'h14, 0);
        `CHK(q[1:0], 2'b11)
        fix <= 10'd0;
        repeat (250) @(negedge clk_i);
        `CHK({pa, na, pb, nb}, 4'b1010)
        do_step(1, 3'd0);
        @(negedge clk_i);
        `CHK({pa, na, pb, nb}, 4'b0110)
        do_step(1, 3'd0);
        @(negedge clk_i);
        `CHK({pa, na, pb, nb}, 4'b0101)
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
